// ---- hdl/sbc_sdram_top.sv ----
module sbc_sdram_top
   import sbc_pkg::*;
(
   input  wire logic                     clk_sys,
   input  wire logic                     rst_n,
   input  wire sbc_pkg::sbc_wb_req_t     wb_req,
   output logic                          wb_ack_o,
   output logic      [31:0]              wb_dat_o,
   input  wire sbc_pkg::sbc_pins_t       pins,
   input  wire logic [sbc_pkg::DQ_W-1:0] dq_in,
   output logic      [sbc_pkg::DQ_W-1:0] dq_out,
   output logic                          dq_oe
);
   import sbc_pkg::*;

   typedef struct packed {
      logic [2:0]                  bl;
      logic                        bt;
      logic [1:0]                  cl;
      logic [ERR_W-1:0]            err;
      logic                        ack;
      logic [31:0]                 rdat;
      logic [NBANK-1:0]            open;
      logic [NBANK-1:0][ROW_W-1:0] row;
      sbc_burst_t                  mode;
      logic                        bank;
      logic [COL_W-1:0]            start;
      logic [COL_W-1:0]            beat;
      logic                        ap;
      logic [1:0]                  pre_cnt;
      logic                        pre_bank;
      logic                        dqm1;
      logic                        v1;
      logic                        v2;
      logic [DQ_W-1:0]             s1;
      logic [DQ_W-1:0]             dq;
      logic                        oe;
   } sbc_state_t;

   sbc_state_t       q;
   sbc_state_t       n;
   sbc_cmd_t         cmd;
   sbc_burst_t       cur_mode;
   logic             ap_lock;
   logic             acc_cmd;
   logic             new_acc;
   logic             full;
   logic             bst_ok;
   logic             cur_bank;
   logic             cur_ap;
   logic             last;
   logic [COL_W-1:0] cur_start;
   logic [COL_W-1:0] cur_beat;
   logic [COL_W-1:0] cur_col;
   logic [ERR_W-1:0] err_set;
   logic [ERR_W-1:0] err_clr;
   logic             wr_hit;
   logic             mem_we;
   logic             mem_re;
   logic [MEM_AW-1:0] mem_addr;
   logic [DQ_W-1:0]  mem_rdata;

   // Command decode straight off the pins, same clock as the controller
   assign cmd     = cmd_decode(pins);
   assign ap_lock = q.ap && (q.mode != BURST_IDLE);
   assign acc_cmd = (cmd == CMD_RD) || (cmd == CMD_WR);
   // Access only to an open bank; an auto-precharge burst can't be cut
   assign new_acc = acc_cmd && q.open[pins.ba] && !ap_lock;
   assign full    = (q.bl == BL_FULL);
   assign bst_ok  = (cmd == CMD_BST) && full &&
                    (q.mode != BURST_IDLE);

   // A new access overrides whatever burst is running
   assign cur_mode  = new_acc ? ((cmd == CMD_RD) ? BURST_RD : BURST_WR)
                    : (bst_ok ? BURST_IDLE : q.mode);
   assign cur_bank  = new_acc ? pins.ba : q.bank;
   assign cur_start = new_acc ? pins.addr[COL_W-1:0] : q.start;
   assign cur_beat  = new_acc ? '0 : q.beat;
   assign cur_ap    = new_acc ? (pins.addr[A_AP] && !full) : q.ap;
   assign last      = !full && (cur_beat == bl_last(q.bl));

   sbc_colgen u_colgen (
      .start (cur_start),
      .beat  (cur_beat),
      .bl    (q.bl),
      .bt    (q.bt),
      .col   (cur_col)
   );

   // Beat 0 of a write uses the data present with the command
   assign mem_addr = {cur_bank, q.row[cur_bank], cur_col};
   assign mem_we   = (cur_mode == BURST_WR) && !pins.dqm;
   assign mem_re   = (cur_mode == BURST_RD);

   sbc_mem #(
      .DW (DQ_W),
      .AW (MEM_AW)
   ) u_mem (
      .clk_sys (clk_sys),
      .we      (mem_we),
      .addr    (mem_addr),
      .wdata   (dq_in),
      .rdata_q (mem_rdata)
   );

   // Misuse by the controller is flagged and not acted on, except a page-mode access with auto-precharge, which runs without it
   assign err_set[ERR_CLOSED]  = acc_cmd && !q.open[pins.ba];
   assign err_set[ERR_BST]     = (cmd == CMD_BST) && !full;
   assign err_set[ERR_AP_FULL] = acc_cmd && pins.addr[A_AP] && full;
   assign err_set[ERR_AP_INTR] = ap_lock &&
                                 (acc_cmd || cmd == CMD_PRE);

   // Bus write lands on the edge that ends the ack cycle, one clock after ack is raised
   assign wr_hit  = q.ack && wb_req.cyc && wb_req.stb && wb_req.we &&
                    wb_req.sel[0];
   assign err_clr = (wr_hit && wb_req.adr == REG_ERR) ?
                    wb_req.dat[ERR_W-1:0] : '0;

   // Next state
   always_comb begin
      n = q;
      n.ack = wb_req.cyc && wb_req.stb && !q.ack;
      if (n.ack) begin
         n.rdat = '0;
         case (wb_req.adr)
            REG_MODE: begin
               n.rdat[MODE_BL_LSB +: 3] = q.bl;
               n.rdat[MODE_BT_BIT]      = q.bt;
               n.rdat[MODE_CL_LSB +: 2] = q.cl;
            end
            REG_STAT: begin
               n.rdat[STAT_OPEN_LSB +: NBANK] = q.open;
               n.rdat[STAT_MODE_LSB +: 2]     = q.mode;
               n.rdat[STAT_AP_BIT]            = ap_lock;
               n.rdat[STAT_PRE_BIT]           = (q.pre_cnt != '0);
            end
            REG_ERR: begin
               n.rdat[ERR_W-1:0] = q.err;
            end
            default: begin
               n.rdat = '0;
            end
         endcase
      end
      if (wr_hit && wb_req.adr == REG_MODE) begin
         n.bl = wb_req.dat[MODE_BL_LSB +: 3];
         n.bt = wb_req.dat[MODE_BT_BIT];
         n.cl = wb_req.dat[MODE_CL_LSB +: 2];
      end
      // Set beats clear so no event is lost
      n.err = (q.err & ~err_clr) | err_set;

      // Burst walk: beat counter wraps freely in page mode
      n.mode  = cur_mode;
      n.bank  = cur_bank;
      n.start = cur_start;
      n.ap    = cur_ap;
      n.beat  = cur_beat + 1'b1;
      // Delayed write auto-precharge closes its bank when the count ends
      if (q.pre_cnt != '0) begin
         n.pre_cnt = q.pre_cnt - 2'h1;
         if (q.pre_cnt == 2'h1) begin
            n.open[q.pre_bank] = 1'b0;
         end
      end
      if (cur_mode != BURST_IDLE && last) begin
         n.mode = BURST_IDLE;
         if (cur_ap) begin
            if (cur_mode == BURST_RD) begin
               // Closes CL-1 clocks ahead of the last data out
               n.open[cur_bank] = 1'b0;
            end else begin
               n.pre_cnt  = WR_TO_PRE_CYC;
               n.pre_bank = cur_bank;
            end
         end
      end
      if (cmd == CMD_ACT) begin
         n.open[pins.ba] = 1'b1;
         n.row[pins.ba]  = pins.addr;
      end
      if (cmd == CMD_PRE && !ap_lock) begin
         if (pins.addr[A_AP]) begin
            n.open = '0;
         end else begin
            n.open[pins.ba] = 1'b0;
         end
      end

      // Read pipe: memory register, then one stage more for latency 3
      n.dqm1 = pins.dqm;
      n.v1   = mem_re;
      n.v2   = q.v1;
      n.s1   = mem_rdata;
      if (q.cl == CL_3) begin
         n.dq = q.s1;
         n.oe = q.v2 && !q.dqm1;
      end else begin
         n.dq = mem_rdata;
         n.oe = q.v1 && !q.dqm1;
      end
   end

   // One register for all state; reset loads constants only
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         q    <= '0;
         q.bl <= BL_RST;
         q.bt <= BT_RST;
         q.cl <= CL_RST;
      end else begin
         q <= n;
      end
   end

   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.rdat;
   assign dq_out   = q.dq;
   assign dq_oe    = q.oe;

   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_rd4_start;
      new_acc && cmd == CMD_RD && q.bl == BL_4;
   endsequence

   sequence s_nop3;
      (cmd == CMD_NOP)[*3];
   endsequence

   AST_ACT_OPENS: assert property (cmd == CMD_ACT |=>
      q.open[$past(pins.ba)] && q.row[$past(pins.ba)] == $past(pins.addr))
      else $error("activate did not open the addressed row");

   AST_PRE_ALL: assert property (
      cmd == CMD_PRE && pins.addr[A_AP] && !ap_lock |=> q.open == '0)
      else $error("precharge all left a bank open");

   AST_RD_LAT2: assert property (
      mem_re && q.cl == CL_2 && !pins.dqm |-> ##2 dq_oe)
      else $error("read data missing at latency two");

   AST_RD_LAT3: assert property (
      mem_re && q.cl == CL_3 ##1 !pins.dqm |-> ##2 dq_oe)
      else $error("read data missing at latency three");

   AST_DQM_READ: assert property (pins.dqm |-> ##2 !dq_oe)
      else $error("mask did not float outputs after two cycles");

   AST_WR_FIRST: assert property (
      cmd == CMD_WR && q.open[pins.ba] && !ap_lock && !pins.dqm |->
      mem_we && mem_addr[COL_W-1:0] == pins.addr[COL_W-1:0])
      else $error("first write beat not taken with the command");

   AST_RD_CUTS_WR: assert property (
      new_acc && cmd == CMD_RD && q.mode == BURST_WR |-> !mem_we)
      else $error("write data stored in the cycle of a read");

   AST_BST_FULL: assert property (
      cmd == CMD_BST && full && q.mode != BURST_IDLE |=>
      q.mode == BURST_IDLE && q.open == $past(q.open))
      else $error("burst stop did not end the page burst");

   AST_BURST_LEN4: assert property (
      s_rd4_start ##1 s_nop3 |-> q.mode == BURST_RD ##1 q.mode == BURST_IDLE)
      else $error("length four burst ran the wrong number of beats");

   AST_SEQ_WRAP: assert property (
      q.mode != BURST_IDLE && !new_acc && !q.bt && q.bl == BL_4 |->
      cur_col[COL_W-1:2] == q.start[COL_W-1:2])
      else $error("sequential burst carried out of its block");

   AST_INTLV: assert property (
      q.mode != BURST_IDLE && !new_acc && q.bt && q.bl == BL_8 |->
      cur_col[2:0] == (q.start[2:0] ^ q.beat[2:0]))
      else $error("interleaved column is not start xor beat");

   AST_WR_AP: assert property (
      q.pre_cnt == WR_TO_PRE_CYC && cmd != CMD_ACT |=>
      q.pre_cnt == 2'h1 ##1 !q.open[$past(q.pre_bank, 2)])
      else $error("write auto-precharge not two clocks after data");

   // Last beat of a read that closes its own bank
   sequence s_rd_ap_end;
      cur_mode == BURST_RD && cur_ap && last && cmd != CMD_ACT;
   endsequence

   AST_RD_RESTART: assert property (
      new_acc && cmd == CMD_RD && q.mode == BURST_RD |=>
      q.beat == 8'h01 && q.start == $past(pins.addr[COL_W-1:0]))
      else $error("interrupting read did not restart its burst");

   AST_WR_RESTART: assert property (
      new_acc && cmd == CMD_WR && q.mode == BURST_WR |=>
      q.start == $past(pins.addr[COL_W-1:0]) && q.beat == 8'h01)
      else $error("interrupting write did not restart its burst");

   AST_BST_DROPS: assert property (
      bst_ok |->
      !mem_we && !mem_re)
      else $error("burst stop let a beat through");

   AST_RD_AP_CLOSE: assert property (
      s_rd_ap_end |=> !q.open[$past(cur_bank)])
      else $error("read auto-precharge left its bank open");

   AST_BST_IGNORED: assert property (
      cmd == CMD_BST && !full |=>
      q.err[ERR_BST])
      else $error("burst stop outside page mode not flagged");
endmodule

// ---- pkg/sbc_pkg.sv ----
package sbc_pkg;
   // Array geometry
   localparam int ROW_W = 11;
   localparam int COL_W = 8;
   localparam int DQ_W  = 16;
   localparam int NBANK = 2;
   localparam int MEM_AW = 1 + ROW_W + COL_W;
   localparam int A_AP  = 10;                 // Auto-precharge / all-banks bit

   // Register map, byte addresses on the bus
   localparam logic [7:0] REG_MODE = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_ERR  = 8'h08;

   // Mode register fields
   localparam int MODE_BL_LSB = 0;
   localparam int MODE_BT_BIT = 3;
   localparam int MODE_CL_LSB = 4;

   // Status register fields
   localparam int STAT_OPEN_LSB = 0;
   localparam int STAT_MODE_LSB = 2;
   localparam int STAT_AP_BIT   = 4;
   localparam int STAT_PRE_BIT  = 5;

   // Sticky error bits, write one to clear
   localparam int ERR_W       = 4;
   localparam int ERR_CLOSED  = 0;
   localparam int ERR_BST     = 1;
   localparam int ERR_AP_FULL = 2;
   localparam int ERR_AP_INTR = 3;

   // Burst length codes and CAS latencies
   localparam logic [2:0] BL_1    = 3'h0;
   localparam logic [2:0] BL_2    = 3'h1;
   localparam logic [2:0] BL_4    = 3'h2;
   localparam logic [2:0] BL_8    = 3'h3;
   localparam logic [2:0] BL_FULL = 3'h7;
   localparam logic [1:0] CL_2    = 2'h2;
   localparam logic [1:0] CL_3    = 2'h3;

   // Reset values of the mode register
   localparam logic [2:0] BL_RST = BL_8;
   localparam logic       BT_RST = 1'b0;
   localparam logic [1:0] CL_RST = CL_2;

   // Clocks from last write beat to start of auto-precharge
   localparam logic [1:0] WR_TO_PRE_CYC = 2'h2;

   typedef enum logic [2:0] {
      CMD_NOP   = 3'h0,
      CMD_ACT   = 3'h1,
      CMD_RD    = 3'h2,
      CMD_WR    = 3'h3,
      CMD_PRE   = 3'h4,
      CMD_BST   = 3'h5,
      CMD_OTHER = 3'h6,
      CMD_DESEL = 3'h7
   } sbc_cmd_t;

   typedef enum logic [1:0] {
      BURST_IDLE = 2'h0,
      BURST_RD   = 2'h1,
      BURST_WR   = 2'h2
   } sbc_burst_t;

   typedef struct packed {
      logic             cs_n;
      logic             ras_n;
      logic             cas_n;
      logic             we_n;
      logic             ba;
      logic [ROW_W-1:0] addr;
      logic             dqm;
   } sbc_pins_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } sbc_wb_req_t;

   // Command pins to command
   function automatic sbc_cmd_t cmd_decode(input sbc_pins_t p);
      logic [2:0] rcw;
      rcw = {p.ras_n, p.cas_n, p.we_n};
      if (p.cs_n) return CMD_DESEL;
      case (rcw)
         3'h7:    return CMD_NOP;
         3'h3:    return CMD_ACT;
         3'h5:    return CMD_RD;
         3'h4:    return CMD_WR;
         3'h2:    return CMD_PRE;
         3'h6:    return CMD_BST;
         default: return CMD_OTHER;
      endcase
   endfunction

   // Index of the last beat; also the mask of wrapping column bits
   function automatic logic [COL_W-1:0] bl_last(input logic [2:0] code);
      case (code)
         BL_1:    return 8'h00;
         BL_2:    return 8'h01;
         BL_4:    return 8'h03;
         BL_8:    return 8'h07;
         default: return 8'hFF;
      endcase
   endfunction
endpackage

// ---- hdl/sbc_mem.sv ----
module sbc_mem #(
   parameter int DW = 16,
   parameter int AW = 20
) (
   input  wire logic          clk_sys,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata_q
);
   logic [DW-1:0] mem [2**AW];

   // Write first cycle, read data one clock later from a register
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata_q <= mem[addr];
   end
endmodule

// ---- hdl/sbc_colgen.sv ----
module sbc_colgen
   import sbc_pkg::*;
(
   input  wire logic [sbc_pkg::COL_W-1:0] start,
   input  wire logic [sbc_pkg::COL_W-1:0] beat,
   input  wire logic [2:0]                bl,
   input  wire logic                      bt,
   output logic      [sbc_pkg::COL_W-1:0] col
);
   import sbc_pkg::*;
   logic [COL_W-1:0] mask;
   logic [COL_W-1:0] step;

   // Only bits under the burst mask move, so no carry leaves the burst
   always_comb begin
      mask = bl_last(bl);
      if (bt && bl != BL_FULL) begin
         step = start ^ beat;
      end else begin
         step = start + beat;
      end
      col = (start & ~mask) | (step & mask);
   end
endmodule

// ---- verification/sbc_ctl_model.sv ----
module sbc_ctl_model
   import sbc_pkg::*;
#(
   parameter int ROW_TO_COLUMN_DELAY = 2,
   parameter int PRECHARGE_TIME      = 2
) (
   input  wire logic                     clk_sys,
   input  wire logic [sbc_pkg::DQ_W-1:0] dq_out,
   input  wire logic                     dq_oe,
   output sbc_pkg::sbc_pins_t            pins,
   output logic      [sbc_pkg::DQ_W-1:0] dq_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic            drv;
   logic [DQ_W-1:0] wd;
   logic [DQ_W-1:0] last;

   // Bus level; a released bus keeps moving, never holds old data
   assign dq_in = dq_oe ? dq_out : (drv ? wd : ~last);
   always @(posedge clk_sys) last <= dq_in;

   // Deselected until the bench starts
   initial begin
      drv  = 1'b0;
      wd   = '0;
      last = '0;
      pins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 11'h000, 1'b0};
   end

   // One command for the cycle after the current edge
   task automatic put(input logic [2:0] rcw, input logic b,
                      input logic [10:0] a, input logic m);
      pins <= '{1'b0, rcw[2], rcw[1], rcw[0], b, a, m};
   endtask

   // Write word for this cycle, or bus released
   task automatic dat(input logic d, input logic [15:0] w);
      drv <= d;
      wd  <= w;
   endtask

   // Open a row, then hold off column access
   task automatic act(input logic b, input logic [10:0] r);
      @(posedge clk_sys);
      put(3'h3, b, r, 1'b0);
      repeat (ROW_TO_COLUMN_DELAY) begin
         @(posedge clk_sys);
         put(3'h7, 1'b0, 11'h000, 1'b0);
      end
   endtask

   // Close one bank or both, then hold off reopening
   task automatic pre(input logic b, input logic all);
      @(posedge clk_sys);
      put(3'h2, b, {all, 10'h000}, 1'b0);
      repeat (PRECHARGE_TIME) begin
         @(posedge clk_sys);
         put(3'h7, 1'b0, 11'h000, 1'b0);
      end
   endtask
endmodule

// ---- verification/sdram_bank_burst_control_bench.sv ----
module sdram_bank_burst_control_bench
   import sbc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic            clk_sys;
   logic            rst_n;
   sbc_wb_req_t     wb_req;
   logic            wb_ack_o;
   logic [31:0]     wb_dat_o;
   sbc_pins_t       pins;
   logic [DQ_W-1:0] dq_in;
   logic [DQ_W-1:0] dq_out;
   logic            dq_oe;
   int              fails;
   int              n_compared;
   logic [31:0]     rnd;
   logic [31:0]     q;
   logic [15:0]     mem [int];
   logic [10:0]     row [2];
   logic [2:0]      blc;
   logic [1:0]      cl;
   logic            bt;
   logic            b;
   logic [7:0]      s;

   sbc_sdram_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_req(wb_req),
      .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .pins(pins),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
   sbc_ctl_model u_ctl (.clk_sys(clk_sys), .dq_out(dq_out), .dq_oe(dq_oe),
      .pins(pins), .dq_in(dq_in));

   // 10 MHz
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic int len();
      return (blc == BL_FULL) ? 256 : 1 << blc;
   endfunction
   // Column of beat k: only the bits inside the burst block move
   function automatic logic [7:0] col_of(input logic [7:0] c, k);
      logic [7:0] m;
      m = (blc == BL_FULL) ? 8'hFF : (8'h01 << blc) - 8'h01;
      return (c & ~m) | ((bt ? c ^ k : c + k) & m);
   endfunction
   function automatic int key(input logic bk, input logic [7:0] c);
      return int'({bk, row[bk], c});
   endfunction

   task automatic complete_run();
      if (fails == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Classic single cycle; held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      wb_req <= '{1'b1, 1'b1, w, 4'hF, a, d};
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         fails++;
         complete_run();
      end else begin
         q = wb_dat_o;
         wb_req <= '0;
      end
   endtask
   task automatic cmd(input logic [2:0] c, input logic bk, input logic [10:0] a);
      @(posedge clk_sys);
      u_ctl.put(c, bk, a, 1'b0);
      @(posedge clk_sys);
      u_ctl.put(3'h7, 1'b0, 11'h000, 1'b0);
   endtask
   // Read at c; command c2 at c3 in cycle ir; mask high in cycle mq
   task automatic rd(input logic bk, input logic [7:0] c, input logic ap,
      input int ir, input logic [2:0] c2, input logic [7:0] c3, input int mq);
      int j;
      int k;
      logic [15:0] e;
      logic o;
      @(posedge clk_sys);
      u_ctl.put(3'h5, bk, {ap, 2'h0, c}, 1'b0);
      for (j = 1; j <= ir + cl + len(); j++) begin
         @(posedge clk_sys);
         if (j == ir) u_ctl.put(c2, bk, {3'h0, c3}, 1'b0);
         else u_ctl.put(3'h7, bk, 11'h000, j == mq);
         @(negedge clk_sys);
         k = j - cl;
         o = 1'b0;
         if (ir > 0 && c2 == 3'h5 && k >= ir) begin
            k = k - ir;
            o = k < len();
            e = mem[key(bk, col_of(c3, 8'(k)))];
         end else if (k >= 0 && k < len() && (ir == 0 || k < ir)) begin
            o = 1'b1;
            e = mem[key(bk, col_of(c, 8'(k)))];
         end
         if (j == mq + 2) o = 1'b0;
         chk("read oe", 32'(dq_oe), 32'(o));
         if (o) chk("read data", 32'(dq_out), 32'(e));
      end
   endtask
   // Write at c; command c2 at c3 in cycle iw; beat mk masked
   task automatic wr(input logic bk, input logic [7:0] c, input logic ap,
      input int iw, input logic [2:0] c2, input logic [7:0] c3, input int mk);
      int j;
      int n;
      logic [7:0] cc;
      n = (iw == 0) ? len() : (c2 == 3'h4) ? iw + len() : iw;
      for (j = 0; j <= n; j++) begin
         @(posedge clk_sys);
         rnd = lfsr(rnd);
         cc = (iw > 0 && j >= iw) ? col_of(c3, 8'(j - iw)) : col_of(c, 8'(j));
         if (j == 0) u_ctl.put(3'h4, bk, {ap, 2'h0, c}, 1'b0);
         else if (j == iw) u_ctl.put(c2, bk, {3'h0, c3}, 1'b0);
         else u_ctl.put(3'h7, bk, 11'h000, j == mk);
         u_ctl.dat(1'b1, rnd[15:0]);
         if (j < n && j != mk) mem[key(bk, cc)] = rnd[15:0];
      end
      @(posedge clk_sys);
      u_ctl.dat(1'b0, 16'h0000);
      u_ctl.put(3'h7, 1'b0, 11'h000, 1'b0);
   endtask

   initial begin
      rst_n = 1'b0;
      wb_req = '0;
      fails = 0;
      n_compared = 0;
      rnd = 32'h5F18;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      // Reset mode, unmapped place reads zero
      wb(1'b0, REG_MODE, 32'h0);
      chk("mode", q, 32'h0000_0023);
      wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
      wb(1'b0, 8'h0C, 32'h0);
      chk("unmapped", q, 32'h0);
      // Lengths 1 to 8, both orders and both latencies; read cut by read, write by write, write by read
      for (int i = 0; i < 16; i++) begin
         blc = {1'b0, i[1:0]};
         bt = i[2];
         cl = i[3] ? CL_3 : CL_2;
         wb(1'b1, REG_MODE, {26'h0, cl, bt, blc});
         rnd = lfsr(rnd);
         b = rnd[0];
         row[b] = rnd[18:8];
         s = rnd[27:20];
         u_ctl.act(b, row[b]);
         wr(b, s, 1'b0, 0, 3'h7, 8'h00, 99);
         wr(b, s, 1'b0, 0, 3'h7, 8'h00, 1);
         rd(b, s, 1'b0, 0, 3'h7, 8'h00, 1);
         rd(b, s, 1'b0, 1, 3'h5, col_of(s, 8'h01), 99);
         wr(b, s, 1'b0, 1, 3'h4, col_of(s, 8'h01), 99);
         rd(b, s, 1'b0, 0, 3'h7, 8'h00, 99);
         wr(b, s, 1'b0, 1, 3'h5, s, 99);
         repeat (12) @(posedge clk_sys);
         rd(b, s, 1'b0, 0, 3'h7, 8'h00, 99);
         u_ctl.pre(b, 1'b0);
         wb(1'b0, REG_STAT, 32'h0);
         chk("closed", q & 32'h3, 32'h0);
      end
      // Page bursts cut by burst stop; bank stays open
      blc = BL_FULL;
      bt = 1'b0;
      cl = CL_2;
      wb(1'b1, REG_MODE, {26'h0, cl, bt, blc});
      row[0] = rnd[10:0];
      row[1] = rnd[21:11];
      u_ctl.act(1'b0, row[0]);
      wr(1'b0, 8'hFC, 1'b0, 6, 3'h6, 8'h00, 99);
      rd(1'b0, 8'hFC, 1'b0, 6, 3'h6, 8'h00, 99);
      wb(1'b0, REG_STAT, 32'h0);
      chk("page open", q & 32'hF, 32'h1);
      u_ctl.pre(1'b0, 1'b0);
      // Auto-precharge on each bank; single and all-bank precharge
      blc = BL_4;
      wb(1'b1, REG_MODE, {26'h0, cl, bt, blc});
      u_ctl.act(1'b0, row[0]);
      u_ctl.act(1'b1, row[1]);
      // Read cut by write; mask keeps the bus free for the write data
      @(posedge clk_sys);
      u_ctl.put(3'h5, 1'b0, 11'h020, 1'b1);
      @(posedge clk_sys);
      u_ctl.put(3'h7, 1'b0, 11'h000, 1'b1);
      wr(1'b0, 8'h20, 1'b0, 0, 3'h7, 8'h00, 99);
      rd(1'b0, 8'h20, 1'b0, 0, 3'h7, 8'h00, 99);
      wr(1'b1, 8'h10, 1'b0, 0, 3'h7, 8'h00, 99);
      wr(1'b0, 8'h20, 1'b1, 0, 3'h7, 8'h00, 99);
      repeat (4) @(posedge clk_sys);
      wb(1'b0, REG_STAT, 32'h0);
      chk("write ap", q & 32'h3, 32'h2);
      rd(1'b1, 8'h10, 1'b1, 0, 3'h7, 8'h00, 99);
      wb(1'b0, REG_STAT, 32'h0);
      chk("read ap", q & 32'h3F, 32'h0);
      u_ctl.act(1'b0, row[0]);
      u_ctl.act(1'b1, row[1]);
      u_ctl.pre(1'b1, 1'b0);
      wb(1'b0, REG_STAT, 32'h0);
      chk("pre one", q & 32'h3, 32'h1);
      u_ctl.pre(1'b0, 1'b1);
      wb(1'b0, REG_STAT, 32'h0);
      chk("pre all", q & 32'h3, 32'h0);
      // Misused commands raise sticky flags, cleared by writing ones
      cmd(3'h5, 1'b0, 11'h000);
      cmd(3'h6, 1'b0, 11'h000);
      u_ctl.act(1'b0, row[0]);
      cmd(3'h5, 1'b0, 11'h400);
      cmd(3'h5, 1'b0, 11'h000);
      repeat (8) @(posedge clk_sys);
      wb(1'b1, REG_MODE, {26'h0, cl, bt, BL_FULL});
      u_ctl.act(1'b0, row[0]);
      cmd(3'h5, 1'b0, 11'h400);
      // Page read runs on without auto-precharge
      wb(1'b0, REG_STAT, 32'h0);
      chk("page read", q & 32'h3F, 32'h5);
      wb(1'b0, REG_ERR, 32'h0);
      chk("errors", q, 32'hF);
      wb(1'b1, REG_ERR, 32'hF);
      wb(1'b0, REG_ERR, 32'h0);
      chk("errors clear", q, 32'h0);
      complete_run();
   end
endmodule
